//--- mts_pkg.sv
// Shared constants for the multiphase token sequencer
package mts_pkg;

  // Clock and timing
  localparam int unsigned CLK_PERIOD_PS      = 5000;
  localparam int unsigned TRIG_SPACING_NS    = 50;
  localparam int unsigned TRIG_SPACING_CYC   = (TRIG_SPACING_NS * 1000 + CLK_PERIOD_PS - 1)
                                               / CLK_PERIOD_PS;
  localparam int unsigned STARTUP_WAIT_CYC   = 4;

  // Ring geometry
  localparam int unsigned PHASE_MAX          = 8;
  localparam int unsigned PHASE_SHIFT_DEG    = 360 / PHASE_MAX;

  // Register offsets
  localparam logic [7:0] REG_RAMP_AMP_CFG    = 8'hd0;
  localparam logic [7:0] REG_PHASE_SHED_CTL  = 8'he5;

  // Reset values
  localparam logic [7:0] RAMP_AMP_CFG_RST    = 8'h00;
  localparam logic [7:0] PHASE_SHED_CTL_RST  = 8'h00;

  // Field positions
  localparam int unsigned RAMP_AMP_LSB       = 1;
  localparam int unsigned RAMP_AMP_MSB       = 3;
  localparam int unsigned SHED_DISABLE_BIT   = 0;
  localparam int unsigned SHED_PIN_SEL_BIT   = 1;

  // Timer width
  localparam int unsigned TMR_W              = 16;

  // Start-up role detection
  typedef enum logic [0:0] {
    ST_WAIT = 1'b0,
    ST_RUN  = 1'b1
  } mts_state_e;

endpackage

//--- mts_timer.sv
// Loadable down-counter that reports busy while counting
`timescale 1ns/1ps
`default_nettype none
module mts_timer
  import mts_pkg::*;
(
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             start,
  input  wire logic [TMR_W-1:0] load,
  output logic                  busy
);

  typedef struct packed {
    logic [TMR_W-1:0] count;
  } mts_tmr_s;

  mts_tmr_s st_q;
  mts_tmr_s st_d;

  // A start while busy restarts the count
  always_comb begin
    st_d = st_q;
    if (start) begin
      st_d.count = load;
    end else if (st_q.count != '0) begin
      st_d.count = st_q.count - 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign busy = (st_q.count != '0);

endmodule
`default_nettype wire

//--- mts_phase_sequencer.sv
// One phase of the interleaved constant-on-time token ring
//
// Contract
// - Up to eight ring phases, 45 degrees apart
// - Token-in high at start-up means master
// - Master alone broadcasts triggers on comparator trip
// - Only an armed phase fires on trigger
// - Firing emits one fixed-width token-out pulse
// - Token-in falling edge arms an enabled phase; wait for trigger
// - High-side switch on for fixed on time
// - On time trimmed from phase and total current
// - Triggers spaced at least fifty nanoseconds
// - Transient triggers limited only by spacing
// - Master fires first; watches power-good faults
// - Slave takes writes only; master reads too
// - Master ramp rises fixed time from each trigger; slaves never ramp
// - Ramp amplitude from config bits three:one
// - Shedding never disables the master phase
// - Shed bit zero set disables slave phases while bit one is clear
// - Shed bit one selects pin; high enables
`timescale 1ns/1ps
`default_nettype none
module mts_phase_sequencer
  import mts_pkg::*;
#(
  parameter logic [TMR_W-1:0] TOKEN_PULSE_CYC = 16'h0014,
  parameter logic [TMR_W-1:0] RAMP_RISE_CYC   = 16'h0028,
  parameter logic [TMR_W-1:0] TRIM_STEP_CYC   = 16'h0002,
  parameter logic [TMR_W-1:0] ON_TIME_MIN_CYC = 16'h0004
)
(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // Ring pins
  input  wire logic        token_in_pin,
  output logic             token_out_pin,
  input  wire logic        trigger_in_pin,
  output logic             trigger_out_pin,
  // Analog interface
  input  wire logic        compare_trip,
  input  wire logic [11:0] on_time_base,
  input  wire logic [11:0] phase_current,
  input  wire logic [15:0] total_current,
  input  wire logic [3:0]  phase_count,
  output logic             high_side_switch,
  output logic             ramp_start,
  output logic             ramp_rising,
  output logic [2:0]       ramp_amplitude,
  // System pins
  input  wire logic        power_good_pin,
  input  wire logic        shed_enable_pin,
  output logic             master_role,
  output logic             role_valid,
  output logic             phase_enabled,
  output logic             slave_fault_seen,
  // Register port
  input  wire logic        reg_wr_en,
  input  wire logic        reg_rd_en,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output logic [7:0]       reg_rdata,
  output logic             reg_rd_valid,
  output logic             reg_rd_refused
);

  typedef struct packed {
    mts_state_e  state;
    logic [2:0]  wait_cnt;
    logic        master;
    logic        tok_s1;
    logic        tok_s2;
    logic        tok_prev;
    logic        trg_s1;
    logic        trg_s2;
    logic        trg_prev;
    logic        cmp_s1;
    logic        cmp_s2;
    logic        pg_s1;
    logic        pg_s2;
    logic        shed_s1;
    logic        shed_s2;
    logic        armed;
    logic        trig_out;
    logic        ramp_go;
    logic        fault;
    logic [7:0]  ramp_cfg;
    logic [7:0]  shed_cfg;
    logic [7:0]  rdata;
    logic        rvalid;
    logic        rrefused;
  } mts_seq_s;

  mts_seq_s st_q;
  mts_seq_s st_d;

  // Timer controls and status
  logic             on_start;
  logic             tok_start;
  logic             space_start;
  logic             ramp_tmr_start;
  logic [TMR_W-1:0] on_load;
  logic             on_busy;
  logic             tok_busy;
  logic             space_busy;
  logic             ramp_busy;

  // Combinational event terms
  logic             running;
  logic             tok_fall;
  logic             trig_evt;
  logic             enabled;
  logic             fire;
  logic             issue_trig;

  // Register read decode, used only by the master read path
  function automatic logic [7:0] reg_read(input logic [7:0] addr,
                                          input logic [7:0] ramp_cfg,
                                          input logic [7:0] shed_cfg);
    logic [7:0] val;
    val = 8'h00;
    case (addr)
      REG_RAMP_AMP_CFG:   val = ramp_cfg;
      REG_PHASE_SHED_CTL: val = shed_cfg;
      default:            val = 8'h00;
    endcase
    return val;
  endfunction

  // Current-sharing trim: compare own current scaled by phase count to total
  function automatic logic [TMR_W-1:0] trim_on_time(input logic [11:0] base,
                                                    input logic [11:0] iphase,
                                                    input logic [15:0] itotal,
                                                    input logic [3:0]  nph);
    logic [15:0]      scaled;
    logic [TMR_W-1:0] t;
    scaled = iphase * nph;
    t      = {4'h0, base};
    if (scaled < itotal) begin
      t = t + TRIM_STEP_CYC;
    end else if (scaled > itotal) begin
      t = (t > TRIM_STEP_CYC + ON_TIME_MIN_CYC) ? t - TRIM_STEP_CYC : ON_TIME_MIN_CYC;
    end
    if (t < ON_TIME_MIN_CYC) begin
      t = ON_TIME_MIN_CYC;
    end
    return t;
  endfunction

  assign running  = (st_q.state == ST_RUN);
  assign tok_fall = st_q.tok_prev & ~st_q.tok_s2;

  // Master reacts to its own trigger; slaves to the broadcast edge
  assign trig_evt = st_q.master ? st_q.trig_out
                                : (st_q.trg_s2 & ~st_q.trg_prev);

  // Master is always enabled; slaves follow bus bit or pin
  assign enabled = st_q.master
                 | (st_q.shed_cfg[SHED_PIN_SEL_BIT] ? st_q.shed_s2
                                                    : ~st_q.shed_cfg[SHED_DISABLE_BIT]);

  // Only the armed, enabled, idle phase switches on
  assign fire = running & trig_evt & st_q.armed & enabled & ~on_busy;

  // Trigger rate bounded only by minimum spacing, so transients repeat fast
  assign issue_trig = running & st_q.master & st_q.cmp_s2 & ~space_busy;

  assign on_load        = trim_on_time(on_time_base, phase_current,
                                       total_current, phase_count);
  assign on_start       = fire;
  // A shed slave still forwards the token so the ring keeps turning
  assign tok_start      = fire | (running & ~enabled & tok_fall);
  assign space_start    = issue_trig;
  assign ramp_tmr_start = issue_trig;

  // Next-state logic
  always_comb begin
    st_d = st_q;

    // Two-flop synchronisers for every pin input
    st_d.tok_s1   = token_in_pin;
    st_d.tok_s2   = st_q.tok_s1;
    st_d.tok_prev = st_q.tok_s2;
    st_d.trg_s1   = trigger_in_pin;
    st_d.trg_s2   = st_q.trg_s1;
    st_d.trg_prev = st_q.trg_s2;
    st_d.cmp_s1   = compare_trip;
    st_d.cmp_s2   = st_q.cmp_s1;
    st_d.pg_s1    = power_good_pin;
    st_d.pg_s2    = st_q.pg_s1;
    st_d.shed_s1  = shed_enable_pin;
    st_d.shed_s2  = st_q.shed_s1;

    st_d.trig_out = issue_trig;
    st_d.ramp_go  = issue_trig;
    st_d.rvalid   = 1'b0;
    st_d.rrefused = 1'b0;

    // Role detection waits for the synchroniser to settle, then latches
    case (st_q.state)
      ST_WAIT: begin
        if (st_q.wait_cnt == STARTUP_WAIT_CYC[2:0]) begin
          st_d.state  = ST_RUN;
          st_d.master = st_q.tok_s2;
          st_d.armed  = st_q.tok_s2;
        end else begin
          st_d.wait_cnt = st_q.wait_cnt + 3'h1;
        end
      end
      ST_RUN: begin
        // Arming wins over the clear of a same-cycle firing
        if (fire) begin
          st_d.armed = 1'b0;
        end
        if (tok_fall & enabled) begin
          st_d.armed = 1'b1;
        end
      end
      default: begin
        st_d.state = ST_WAIT;
      end
    endcase

    // Slaves pull power-good low to flag a fault; sticky until reset
    if (running & st_q.master & ~st_q.pg_s2) begin
      st_d.fault = 1'b1;
    end

    // Register writes are accepted by every phase
    if (reg_wr_en) begin
      case (reg_addr)
        REG_RAMP_AMP_CFG:   st_d.ramp_cfg = reg_wdata;
        REG_PHASE_SHED_CTL: st_d.shed_cfg = reg_wdata;
        default: begin
        end
      endcase
    end

    // Reads are answered only by the master
    if (reg_rd_en) begin
      if (running & st_q.master) begin
        st_d.rdata  = reg_read(reg_addr, st_q.ramp_cfg, st_q.shed_cfg);
        st_d.rvalid = 1'b1;
      end else begin
        st_d.rrefused = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_q          <= '0;
      st_q.state    <= ST_WAIT;
      st_q.ramp_cfg <= RAMP_AMP_CFG_RST;
      st_q.shed_cfg <= PHASE_SHED_CTL_RST;
      st_q.pg_s1    <= 1'b1;
      st_q.pg_s2    <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // On-time timer drives the high-side switch
  mts_timer u_on_tmr (
    .clk_sys (clk_sys),
    .rst     (rst),
    .start   (on_start),
    .load    (on_load),
    .busy    (on_busy)
  );

  // Fixed-width token pulse toward the next phase
  mts_timer u_tok_tmr (
    .clk_sys (clk_sys),
    .rst     (rst),
    .start   (tok_start),
    .load    (TOKEN_PULSE_CYC),
    .busy    (tok_busy)
  );

  // Loads one less than the spacing, since the issuing cycle passes before busy rises
  mts_timer u_space_tmr (
    .clk_sys (clk_sys),
    .rst     (rst),
    .start   (space_start),
    .load    (TMR_W'(TRIG_SPACING_CYC - 1)),
    .busy    (space_busy)
  );

  // Fixed ramp rise window, independent of amplitude
  mts_timer u_ramp_tmr (
    .clk_sys (clk_sys),
    .rst     (rst),
    .start   (ramp_tmr_start),
    .load    (RAMP_RISE_CYC),
    .busy    (ramp_busy)
  );

  // Outputs; switch and token come straight from timer counts
  assign high_side_switch = on_busy;
  assign token_out_pin    = tok_busy;
  assign trigger_out_pin  = st_q.trig_out;
  assign ramp_start       = st_q.ramp_go;
  assign ramp_rising      = ramp_busy;
  assign ramp_amplitude   = st_q.ramp_cfg[RAMP_AMP_MSB:RAMP_AMP_LSB];
  assign master_role      = st_q.master;
  assign role_valid       = running;
  assign phase_enabled    = enabled;
  assign slave_fault_seen = st_q.fault;
  assign reg_rdata        = st_q.rdata;
  assign reg_rd_valid     = st_q.rvalid;
  assign reg_rd_refused   = st_q.rrefused;

endmodule
`default_nettype wire

//--- mts_seq_properties.sv
// Port timing checker for one ring phase
`timescale 1ns/1ps
`default_nettype none
module mts_seq_chk
  import mts_pkg::*;
#(parameter logic [TMR_W-1:0] TOKEN_PULSE_CYC = 16'h0014)
(
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic       trigger_out_pin,
  input wire logic       ramp_start,
  input wire logic       high_side_switch,
  input wire logic       token_out_pin,
  input wire logic       reg_rd_en,
  input wire logic       reg_rd_valid,
  input wire logic       reg_rd_refused,
  input wire logic       master_role,
  input wire logic       role_valid,
  input wire logic       phase_enabled,
  input wire logic       reg_wr_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [2:0] ramp_amplitude
);
  logic [15:0] tok_q;
  // Token pulse length so far; a counter keeps the width check cheap
  always_ff @(posedge clk_sys) begin
    if (rst) tok_q <= 16'h0000;
    else tok_q <= token_out_pin ? tok_q + 16'h0001 : 16'h0000;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_quiet;
    (!trigger_out_pin)[*8] ##1 !trigger_out_pin;
  endsequence
  property p_rs; trigger_out_pin |-> ramp_start; endproperty
  property p_trig_m; trigger_out_pin |-> master_role && role_valid; endproperty
  property p_space; trigger_out_pin |=> s_quiet; endproperty
  property p_rd_ok; reg_rd_en && master_role && role_valid |=> reg_rd_valid; endproperty
  property p_rd_ref;
    reg_rd_en && !(master_role && role_valid) |=> reg_rd_refused && !reg_rd_valid;
  endproperty
  property p_tok_hs; $rose(high_side_switch) |-> $rose(token_out_pin); endproperty
  property p_tok_w; $fell(token_out_pin) |-> tok_q == TOKEN_PULSE_CYC; endproperty
  property p_amp;
    reg_wr_en && reg_addr == REG_RAMP_AMP_CFG |-> ##2 ramp_amplitude == $past(reg_wdata[3:1], 2);
  endproperty
  property p_mst_en; master_role && role_valid |-> phase_enabled; endproperty
  a_rs: assert property (p_rs) else $error("no ramp start");
  a_trig_m: assert property (p_trig_m) else $error("slave trigger");
  a_space: assert property (p_space) else $error("trigger spacing");
  a_rd_ok: assert property (p_rd_ok) else $error("read not answered");
  a_rd_ref: assert property (p_rd_ref) else $error("read not refused");
  a_tok_hs: assert property (p_tok_hs) else $error("no token on fire");
  a_tok_w: assert property (p_tok_w) else $error("token width");
  a_amp: assert property (p_amp) else $error("ramp amplitude");
  a_mst_en: assert property (p_mst_en) else $error("master shed");
endmodule
bind mts_phase_sequencer mts_seq_chk #(.TOKEN_PULSE_CYC(TOKEN_PULSE_CYC)) u_chk (
  .clk_sys(clk_sys), .rst(rst), .trigger_out_pin(trigger_out_pin), .ramp_start(ramp_start),
  .high_side_switch(high_side_switch), .token_out_pin(token_out_pin), .reg_rd_en(reg_rd_en),
  .reg_rd_valid(reg_rd_valid), .reg_rd_refused(reg_rd_refused), .master_role(master_role),
  .role_valid(role_valid), .phase_enabled(phase_enabled), .reg_wr_en(reg_wr_en),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .ramp_amplitude(ramp_amplitude));
`default_nettype wire

//--- mts_ring_nbr.sv
// Model of the neighbouring phase feeding token and trigger pins
`timescale 1ns/1ps
`default_nettype none
module mts_ring_nbr (
  input  wire logic clk_sys,
  input  wire logic hold_hi,
  input  wire logic pass_req,
  input  wire logic trig_req,
  output logic      token_in_pin,
  output logic      trigger_in_pin
);
  int tok_n = 0;
  initial trigger_in_pin = 1'b0;
  // Token pulse ends in a falling edge; pull-up level stands for master strap
  always @(posedge clk_sys) begin
    tok_n <= pass_req ? 4 : (tok_n > 0 ? tok_n - 1 : 0);
    trigger_in_pin <= trig_req;
  end
  assign token_in_pin = hold_hi | (tok_n > 0);
endmodule
`default_nettype wire

//--- testbench.sv
// Self-checking bench for one ring phase, master then slave
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import mts_pkg::*;
  logic clk_sys = 1'b0, rst = 1'b1, compare_trip = 1'b0;
  logic power_good_pin = 1'b1, shed_enable_pin = 1'b1;
  logic reg_wr_en = 1'b0, reg_rd_en = 1'b0, hold_hi = 1'b1, pass_req = 1'b0, trig_req = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, r;
  logic [11:0] on_time_base = 12'h010, phase_current = 0;
  logic [15:0] total_current = 0;
  logic [3:0] phase_count = 4'h1;
  logic token_in_pin, token_out_pin, trigger_in_pin, trigger_out_pin, high_side_switch;
  logic ramp_start, ramp_rising, master_role, role_valid, phase_enabled, slave_fault_seen;
  logic reg_rd_valid, reg_rd_refused;
  logic [2:0] ramp_amplitude;
  logic [4:0] sb0 = 5'b10010, sb1 = 5'b11100, spin = 5'b10111, sen = 5'b10101;
  int num_errors = 0, checked = 0, hs_c = 0, hs_w = 0, hs_n = 0, tok_c = 0, tok_w = 0;
  int trig_n = 0, i, k, b, ip, it, n, hs_e, rmp_c = 0, rmp_w = 0;
  int seed = 32'h73dbf8f3;
  mts_phase_sequencer u_mts_phase_sequencer (.clk_sys(clk_sys), .rst(rst),
    .token_in_pin(token_in_pin), .token_out_pin(token_out_pin),
    .trigger_in_pin(trigger_in_pin), .trigger_out_pin(trigger_out_pin),
    .compare_trip(compare_trip), .on_time_base(on_time_base), .phase_current(phase_current),
    .total_current(total_current), .phase_count(phase_count),
    .high_side_switch(high_side_switch), .ramp_start(ramp_start), .ramp_rising(ramp_rising),
    .ramp_amplitude(ramp_amplitude), .power_good_pin(power_good_pin),
    .shed_enable_pin(shed_enable_pin), .master_role(master_role), .role_valid(role_valid),
    .phase_enabled(phase_enabled), .slave_fault_seen(slave_fault_seen),
    .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid),
    .reg_rd_refused(reg_rd_refused));
  mts_ring_nbr u_mts_ring_nbr (.clk_sys(clk_sys), .hold_hi(hold_hi), .pass_req(pass_req),
    .trig_req(trig_req), .token_in_pin(token_in_pin), .trigger_in_pin(trigger_in_pin));
  initial begin
    forever #2.5 clk_sys = ~clk_sys;
  end
  // Widths and counts sampled away from the active edge
  always @(negedge clk_sys) begin
    if (trigger_out_pin === 1'b1) trig_n++;
    if (high_side_switch === 1'b1) hs_c++;
    else if (hs_c > 0) begin
      hs_w = hs_c;
      hs_c = 0;
      hs_n++;
    end
    // A new trigger restarts the ramp, so only an undisturbed rise gives a width
    if (ramp_start === 1'b1) rmp_c = 1;
    else if (ramp_rising === 1'b1) rmp_c++;
    else if (rmp_c > 0) begin
      rmp_w = rmp_c;
      rmp_c = 0;
    end
    if (token_out_pin === 1'b1) tok_c++;
    else if (tok_c > 0) begin
      tok_w = tok_c;
      tok_c = 0;
    end
  end
  // Reference on time: one trim step toward balance, floored at the minimum
  function automatic int exp_on(int bb, int pi, int ti, int nn);
    int t;
    t = bb + (pi * nn < ti ? 2 : (pi * nn > ti ? -2 : 0));
    return t < 4 ? 4 : t;
  endfunction
  task automatic tally_and_finish();
    $display("checked=%0d num_errors=%0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input bit ok, input string m);
    checked++;
    if (!ok) begin
      num_errors++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  // Strobes stand for a host that has already addressed this phase
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    reg_wr_en <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk_sys);
    reg_wr_en <= 1'b0;
  endtask
  // Master reads must answer with data, slave reads are refused
  task automatic rd(input logic [7:0] a, input logic mst, input logic [7:0] ex);
    @(posedge clk_sys);
    reg_rd_en <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd_en <= 1'b0;
    #1;
    if (mst) chk(reg_rd_valid === 1'b1 && reg_rdata === ex, "read data");
    else chk(reg_rd_refused === 1'b1 && reg_rd_valid === 1'b0, "read refuse");
  endtask
  task automatic do_reset();
    rst <= 1'b1;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    for (i = 0; i < 20 && role_valid !== 1'b1; i++) @(posedge clk_sys);
    if (role_valid !== 1'b1) begin
      chk(1'b0, "role wait");
      tally_and_finish();
    end
  endtask
  initial begin
    #400000;
    chk(1'b0, "timeout");
    tally_and_finish();
  end
  initial begin
    do_reset();
    chk(master_role === 1'b1, "not master");
    rd(8'hd0, 1'b1, RAMP_AMP_CFG_RST);
    rd(8'he5, 1'b1, PHASE_SHED_CTL_RST);
    rd(8'h42, 1'b1, 8'h00);
    r = 8'($random(seed));
    wr(8'hd0, r);
    rd(8'hd0, 1'b1, r);
    chk(ramp_amplitude === r[3:1], "amplitude");
    wr(8'he5, 8'h01);
    chk(phase_enabled === 1'b1, "master shed");
    b = 10 + ($random(seed) & 15);
    ip = 8 + ($random(seed) & 255);
    n = 1 + ($random(seed) & 7);
    it = ip * n + (($random(seed) & 3) - 1) * 4;
    on_time_base <= b[11:0];
    phase_current <= ip[11:0];
    total_current <= it[15:0];
    phase_count <= n[3:0];
    hold_hi <= 1'b0;
    repeat (6) @(posedge clk_sys);
    hs_e = hs_n;
    trig_n = 0;
    compare_trip <= 1'b1;
    repeat (100) @(posedge clk_sys);
    chk(trig_n == 10, "trigger count");
    chk(hs_n == hs_e + 1, "first fire only");
    chk(hs_w == exp_on(b, ip, it, n), "on time");
    chk(tok_w == 20, "token width");
    pass_req <= 1'b1;
    @(posedge clk_sys);
    pass_req <= 1'b0;
    repeat (60) @(posedge clk_sys);
    chk(hs_n == hs_e + 2, "armed refire");
    compare_trip <= 1'b0;
    power_good_pin <= 1'b0;
    repeat (45) @(posedge clk_sys);
    chk(slave_fault_seen === 1'b1, "fault flag");
    chk(rmp_w == 40, "ramp rise");
    $display("master test done");
    power_good_pin <= 1'b1;
    do_reset();
    chk(master_role === 1'b0 && slave_fault_seen === 1'b0
        && ramp_amplitude === RAMP_AMP_CFG_RST[3:1], "slave role");
    rd(8'hd0, 1'b0, 8'h00);
    for (k = 0; k < 5; k++) begin
      wr(8'he5, {6'h00, sb1[k], sb0[k]});
      shed_enable_pin <= spin[k];
      repeat (4) @(posedge clk_sys);
      chk(phase_enabled === sen[k], "shed enable");
      // A shed slave must still hand the token on, without arming itself
      if (k == 1) begin
        tok_w = 0;
        pass_req <= 1'b1;
        @(posedge clk_sys);
        pass_req <= 1'b0;
        repeat (30) @(posedge clk_sys);
        chk(tok_w == 20, "shed forward");
      end
    end
    hs_e = hs_n;
    trig_n = 0;
    compare_trip <= 1'b1;
    trig_req <= 1'b1;
    @(posedge clk_sys);
    trig_req <= 1'b0;
    repeat (12) @(posedge clk_sys);
    chk(hs_n == hs_e, "unarmed fire");
    pass_req <= 1'b1;
    @(posedge clk_sys);
    pass_req <= 1'b0;
    repeat (12) @(posedge clk_sys);
    trig_req <= 1'b1;
    @(posedge clk_sys);
    trig_req <= 1'b0;
    repeat (60) @(posedge clk_sys);
    chk(hs_n == hs_e + 1 && trig_n == 0, "slave fire");
    chk(hs_w == exp_on(b, ip, it, n), "slave on time");
    $display("slave test done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
